/* secv_code_ctrl.sv */
`timescale 1ns/100ps
// How it works
// - verify compares codes only when the code is enabled and not blocked
// - correct verify reloads the attempt counter to three
// - wrong verify decrements the counter, on any logical channel
// - first wrong answer 63C2, second consecutive wrong answer 63C1
// - third consecutive wrong presentation blocks the code, answer 63C0
// - verify with data on a blocked code answers 6983
// - verified status is one flag per code, shared by every channel
// - access granted only after verification, unless the code is disabled
// - empty verify reports remaining attempts as 63CX, even if disabled
// - empty verify on a blocked code answers 6983
// - low five parameter bits are reference 01..1F, bits 7,6 zero, zero unsupported
// - parameter bit 8 picks global or specific reference data
// - change acts only when the code is enabled and not blocked
// - correct old code reloads counter and installs new code at once
// - wrong old code decrements counter, keeps code, blocks after three
// - blocked code never grants access until it is reloaded
module secv_code_ctrl #(
   parameter int NUM_SLOTS = 64
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq
);
   import secv_pkg::*;

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   generate
      if (NUM_SLOTS != 64) begin : g_bad_slots
         $error("secv_code_ctrl: NUM_SLOTS must be 64");
      end
   endgenerate

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } secv_state_t;

   // ----------------------------------------------------------------
   // storage and registers
   // ----------------------------------------------------------------
   secv_slot_t          st_mem   [NUM_SLOTS];
   logic       [63:0]   code_mem [NUM_SLOTS];
   secv_state_t         state;
   secv_cmd_t           cmd;
   logic       [31:0]   data     [4];
   logic       [15:0]   result_sw;
   secv_slot_t          last_st;
   logic [IRQ_W-1:0]    irq_status;
   logic [IRQ_W-1:0]    irq_mask;
   logic [IRQ_W-1:0]    rd_clear;
   logic [SLOT_W-1:0]   access_slot;

   logic                setup;
   logic                access;
   logic                wr_acc;
   logic                rd_setup;
   logic                mapped;
   logic [31:0]         next_prdata;

   logic                p2_ok;
   logic [SLOT_W-1:0]   slot;
   secv_slot_t          cur_st;
   logic [63:0]         cur_code;
   secv_slot_t          next_st;
   logic [63:0]         next_code;
   logic [15:0]         next_sw;
   logic                ev_wrong;
   logic                ev_block;
   logic                exec;
   logic                grant;

   // qualifier decode, used only for the command; the access port takes a raw slot number
   function automatic logic p2_valid(input logic [7:0] q);
      return (q[6:5] == 2'b00) && (q[4:0] != 5'h00);
   endfunction

   function automatic logic [SLOT_W-1:0] p2_slot(input logic [7:0] q);
      return {q[7], q[4:0]};
   endfunction

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign setup    = psel && !penable;
   assign access   = psel && penable && pready;
   assign wr_acc   = access && pwrite && !pslverr;
   assign rd_setup = setup && !pwrite;
   assign exec     = (state == ST_EXEC);

   // map lookup; anything off the map answers with pslverr
   always_comb begin
      mapped      = 1'b1;
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         OFS_CMD:        next_prdata = cmd;
         OFS_DATA0:      next_prdata = data[0];
         OFS_DATA1:      next_prdata = data[1];
         OFS_DATA2:      next_prdata = data[2];
         OFS_DATA3:      next_prdata = data[3];
         OFS_RESULT:     next_prdata = {10'h000, last_st, exec, result_sw};
         OFS_IRQ_STATUS: next_prdata = {29'h0000_0000, irq_status};
         OFS_IRQ_MASK:   next_prdata = {29'h0000_0000, irq_mask};
         OFS_ACCESS:     next_prdata = {18'h0_0000, st_mem[access_slot], grant, 2'b00, access_slot};
         OFS_SESSION:    next_prdata = 32'h0000_0000;
         default:        mapped      = 1'b0;
      endcase
   end

   // answer prepared in the setup cycle so the access phase has no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= rd_setup ? next_prdata : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // a command write while busy is dropped; the command stays stable during exec
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd         <= '0;
         access_slot <= '0;
         irq_mask    <= '0;
         for (int i = 0; i < 4; i++) begin
            data[i] <= 32'h0000_0000;
         end
      end else if (wr_acc) begin
         unique case (paddr)
            OFS_CMD:      if (!exec) cmd <= pwdata;
            OFS_DATA0:    data[0] <= pwdata;
            OFS_DATA1:    data[1] <= pwdata;
            OFS_DATA2:    data[2] <= pwdata;
            OFS_DATA3:    data[3] <= pwdata;
            OFS_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
            OFS_ACCESS:   access_slot <= pwdata[SLOT_W-1:0];
            default:      ;
         endcase
      end
   end

   // one cycle of execution per accepted command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else if (exec) begin
         state <= ST_IDLE;
      end else if (wr_acc && paddr == OFS_CMD) begin
         state <= ST_EXEC;
      end
   end

   // ----------------------------------------------------------------
   // command execution
   // ----------------------------------------------------------------
   assign p2_ok    = p2_valid(cmd.p2);
   assign slot     = p2_slot(cmd.p2);
   assign cur_st   = st_mem[slot];
   assign cur_code = code_mem[slot];

   always_comb begin
      next_st   = cur_st;
      next_code = cur_code;
      next_sw   = SW_OK;
      ev_wrong  = 1'b0;
      ev_block  = 1'b0;
      if (!p2_ok) begin
         next_sw = SW_BAD_P2;
      end else begin
         unique case (cmd.op)
            OP_VERIFY: begin
               if (cmd.lc == LC_EMPTY) begin
                  // retry query works on disabled codes too
                  next_sw = cur_st.blocked ? SW_BLOCKED :
                            {SW_RETRY_HI, 2'b00, cur_st.retries};
               end else if (cur_st.blocked) begin
                  // blocked wins over a bad length: any code data gets 6983
                  next_sw = SW_BLOCKED;
               end else if (cmd.lc != LC_VERIFY) begin
                  next_sw = SW_WRONG_LC;
               end else if (cur_st.disabled) begin
                  next_sw = SW_COND;
               end else if ({data[0], data[1]} == cur_code) begin
                  next_st.retries  = RETRY_INIT;
                  next_st.verified = 1'b1;
               end else begin
                  // channel field is ignored: the counter is per code
                  ev_wrong         = 1'b1;
                  next_st.retries  = cur_st.retries - 2'h1;
                  next_st.verified = 1'b0;
                  next_sw          = {SW_RETRY_HI, 2'b00, cur_st.retries - 2'h1};
                  if (cur_st.retries == 2'h1) begin
                     next_st.blocked = 1'b1;
                     ev_block        = 1'b1;
                  end
               end
            end
            OP_CHANGE: begin
               if (cmd.lc != LC_CHANGE) begin
                  next_sw = SW_WRONG_LC;
               end else if (cur_st.blocked) begin
                  next_sw = SW_BLOCKED;
               end else if (cur_st.disabled) begin
                  next_sw = SW_COND;
               end else if ({data[0], data[1]} == cur_code) begin
                  next_st.retries = RETRY_INIT;
                  next_code       = {data[2], data[3]};
               end else begin
                  ev_wrong         = 1'b1;
                  next_st.retries  = cur_st.retries - 2'h1;
                  next_st.verified = 1'b0;
                  next_sw          = {SW_RETRY_HI, 2'b00, cur_st.retries - 2'h1};
                  if (cur_st.retries == 2'h1) begin
                     next_st.blocked = 1'b1;
                     ev_block        = 1'b1;
                  end
               end
            end
            OP_LOAD: begin
               // provisioning and unblock_code_cmd: no check here, trusted software
               next_code = {data[0], data[1]};
               next_st   = SLOT_RESET;
            end
            OP_DISABLE: next_st.disabled = 1'b1;
            OP_ENABLE:  next_st.disabled = 1'b0;
            default:    next_sw = SW_BAD_INS;
         endcase
      end
   end

   // code state; a session clear drops only verified flags, never counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            st_mem[i]   <= SLOT_RESET;
            code_mem[i] <= CODE_RESET;
         end
      end else begin
         if (wr_acc && paddr == OFS_SESSION && pwdata[0]) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
               st_mem[i].verified <= 1'b0;
            end
         end
         if (exec) begin
            st_mem[slot]   <= next_st;
            code_mem[slot] <= next_code;
         end
      end
   end

   // answer of the last command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_sw <= SW_OK;
         last_st   <= SLOT_RESET;
      end else if (exec) begin
         result_sw <= next_sw;
         last_st   <= next_st;
      end
   end

   // grant: blocked never, disabled always, else only when verified
   assign grant = !st_mem[access_slot].blocked &&
                  (st_mem[access_slot].disabled || st_mem[access_slot].verified);

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   // clear only what the read captured, so a new event is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_clear <= '0;
      end else begin
         rd_clear <= (rd_setup && paddr == OFS_IRQ_STATUS) ? irq_status : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= (access && !pwrite && paddr == OFS_IRQ_STATUS ? irq_status & ~rd_clear : irq_status)
                       | {exec && ev_block, exec && ev_wrong, exec};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic ok_verify;
   logic bad_verify;
   assign ok_verify  = exec && p2_ok && cmd.op == OP_VERIFY && cmd.lc == LC_VERIFY &&
                       !cur_st.blocked && !cur_st.disabled && {data[0], data[1]} == cur_code;
   assign bad_verify = exec && p2_ok && cmd.op == OP_VERIFY && cmd.lc == LC_VERIFY &&
                       !cur_st.blocked && !cur_st.disabled && {data[0], data[1]} != cur_code;

   property p_disabled_no_compare;
      @(posedge pclk) disable iff (!presetn)
      exec && p2_ok && cmd.op == OP_VERIFY && cmd.lc == LC_VERIFY && !cur_st.blocked && cur_st.disabled
      |=> result_sw == SW_COND && last_st.retries == $past(cur_st.retries);
   endproperty
   a_disabled_no_compare: assert property (p_disabled_no_compare) else $error("disabled code was compared");

   property p_verify_ok;
      @(posedge pclk) disable iff (!presetn)
      ok_verify |=> result_sw == SW_OK && last_st.retries == 2'h3 && last_st.verified;
   endproperty
   a_verify_ok: assert property (p_verify_ok) else $error("correct code did not reload counter");

   property p_verify_bad;
      @(posedge pclk) disable iff (!presetn)
      bad_verify |=> last_st.retries == $past(cur_st.retries) - 2'h1 && irq_status[IRQ_WRONG];
   endproperty
   a_verify_bad: assert property (p_verify_bad) else $error("wrong code did not decrement");

   property p_first_wrong;
      @(posedge pclk) disable iff (!presetn)
      bad_verify && cur_st.retries == 2'h3 |=> result_sw == 16'h63C2;
   endproperty
   a_first_wrong: assert property (p_first_wrong) else $error("first wrong code not 63C2");

   property p_third_wrong;
      @(posedge pclk) disable iff (!presetn)
      bad_verify && cur_st.retries == 2'h1 |=> result_sw == 16'h63C0 && last_st.blocked && irq_status[IRQ_BLOCK];
   endproperty
   a_third_wrong: assert property (p_third_wrong) else $error("third wrong code did not block");

   property p_blocked_verify;
      @(posedge pclk) disable iff (!presetn)
      exec && p2_ok && cmd.op == OP_VERIFY && cur_st.blocked |=> result_sw == SW_BLOCKED && last_st.blocked;
   endproperty
   a_blocked_verify: assert property (p_blocked_verify) else $error("blocked code not answered 6983");

   property p_retry_query;
      @(posedge pclk) disable iff (!presetn)
      exec && p2_ok && cmd.op == OP_VERIFY && cmd.lc == LC_EMPTY && !cur_st.blocked
      |=> result_sw == {12'h63C, 2'b00, $past(cur_st.retries)} && last_st == $past(cur_st);
   endproperty
   a_retry_query: assert property (p_retry_query) else $error("retry query wrong or changed state");

   property p_bad_p2;
      @(posedge pclk) disable iff (!presetn)
      exec && !p2_ok |=> result_sw == SW_BAD_P2 && code_mem[$past(slot)] == $past(cur_code);
   endproperty
   a_bad_p2: assert property (p_bad_p2) else $error("invalid qualifier accepted");

   property p_change_ok;
      @(posedge pclk) disable iff (!presetn)
      exec && p2_ok && cmd.op == OP_CHANGE && cmd.lc == LC_CHANGE && !cur_st.blocked && !cur_st.disabled &&
      {data[0], data[1]} == cur_code |=> code_mem[$past(slot)] == $past({data[2], data[3]}) && last_st.retries == 2'h3;
   endproperty
   a_change_ok: assert property (p_change_ok) else $error("change did not install new code");

   property p_blocked_no_grant;
      @(posedge pclk) disable iff (!presetn)
      exec && cur_st.blocked && cmd.op != OP_LOAD |=> last_st.blocked && !last_st.verified;
   endproperty
   a_blocked_no_grant: assert property (p_blocked_no_grant) else $error("blocked code granted access");

   property p_irq_level;
      @(posedge pclk) disable iff (!presetn)
      |(irq_status & irq_mask) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("unmasked event without interrupt");

   c_block: cover property (@(posedge pclk) disable iff (!presetn) exec && ev_block);
   c_change: cover property (@(posedge pclk) disable iff (!presetn) exec && cmd.op == OP_CHANGE && next_sw == SW_OK);
   c_query: cover property (@(posedge pclk) disable iff (!presetn) exec && cmd.lc == LC_EMPTY && cur_st.blocked);
   c_grant: cover property (@(posedge pclk) disable iff (!presetn) grant && !st_mem[access_slot].disabled);

endmodule // secv_code_ctrl

/* secv_pkg.sv */
package secv_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CMD        = 8'h00;
   localparam logic [7:0] OFS_DATA0      = 8'h04;
   localparam logic [7:0] OFS_DATA1      = 8'h08;
   localparam logic [7:0] OFS_DATA2      = 8'h0C;
   localparam logic [7:0] OFS_DATA3      = 8'h10;
   localparam logic [7:0] OFS_RESULT     = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h1C;
   localparam logic [7:0] OFS_ACCESS     = 8'h20;
   localparam logic [7:0] OFS_SESSION    = 8'h24;

   // ----------------------------------------------------------------
   // command coding
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_VERIFY  = 8'h00;
   localparam logic [7:0] OP_CHANGE  = 8'h01;
   localparam logic [7:0] OP_LOAD    = 8'h02;   // unblock_code_cmd stand-in
   localparam logic [7:0] OP_DISABLE = 8'h03;
   localparam logic [7:0] OP_ENABLE  = 8'h04;
   localparam logic [7:0] LC_EMPTY   = 8'h00;
   localparam logic [7:0] LC_VERIFY  = 8'h08;
   localparam logic [7:0] LC_CHANGE  = 8'h10;

   // ----------------------------------------------------------------
   // status words
   // ----------------------------------------------------------------
   localparam logic [15:0] SW_OK       = 16'h9000;
   localparam logic [11:0] SW_RETRY_HI = 12'h63C;
   localparam logic [15:0] SW_BLOCKED  = 16'h6983;
   localparam logic [15:0] SW_COND     = 16'h6985;
   localparam logic [15:0] SW_WRONG_LC = 16'h6700;
   localparam logic [15:0] SW_BAD_P2   = 16'h6A86;
   localparam logic [15:0] SW_BAD_INS  = 16'h6D00;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [1:0]  RETRY_INIT   = 2'h3;
   localparam logic [63:0] CODE_RESET   = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam int          IRQ_DONE     = 0;
   localparam int          IRQ_WRONG    = 1;
   localparam int          IRQ_BLOCK    = 2;
   localparam int          IRQ_W        = 3;
   localparam int          SLOT_W       = 6;

   typedef struct packed {
      logic [5:0] rsvd;
      logic [1:0] chan;     // logical channel, carried but not used
      logic [7:0] lc;
      logic [7:0] p2;
      logic [7:0] op;
   } secv_cmd_t;

   typedef struct packed {
      logic       blocked;
      logic       disabled;
      logic       verified;
      logic [1:0] retries;
   } secv_slot_t;

   localparam secv_slot_t SLOT_RESET = '{blocked: 1'b0, disabled: 1'b0, verified: 1'b0, retries: 2'h3};

endpackage

/* secv_term.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// terminal side: apb master issuing command frames
// ----------------------------------------------------------------
module secv_term (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   import secv_pkg::*;

   // idle bus at time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h00000000;
   end

   // one transfer; request held until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;   // released data must not look valid
      @(posedge pclk);
   endtask

   // full frame: code words, then command, then poll until not busy
   task automatic cmd(input logic [7:0] op, p2, lc, input logic [31:0] a, b, output logic [31:0] res);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, OFS_DATA0, a, q, e);
      xfer(1'b1, OFS_DATA1, a, q, e);
      xfer(1'b1, OFS_DATA2, b, q, e);   // eight old then eight new bytes
      xfer(1'b1, OFS_DATA3, b, q, e);
      xfer(1'b1, OFS_CMD, {8'h00, lc, p2, op}, q, e);
      res = 32'h00010000;
      while (res[16] !== 1'b0) xfer(1'b0, OFS_RESULT, 32'h0, res, e);
   endtask
endmodule // secv_term

/* test_secv_code_ctrl.sv */
`timescale 1ns/100ps
module test_secv_code_ctrl;
   import secv_pkg::*;

   typedef struct packed {
      logic [7:0]  op, p2, lc;
      logic [31:0] a, b;
      logic [15:0] sw;
   } secv_row_t;

   localparam logic [31:0] ONES = 32'hFFFFFFFF;
   localparam logic [31:0] NEWC = 32'h12345678;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        e;
   int          failures, total_checks;

   // ----------------------------------------------------------------
   // ordinary cases: slot 1 walked to blocked, then qualifier and disable
   // ----------------------------------------------------------------
   secv_row_t rows [19] = '{
      '{8'h00, 8'h01, 8'h00, 32'h0, 32'h0, 16'h63C3},
      '{8'h00, 8'h01, 8'h08, 32'h0, 32'h0, 16'h63C2},
      '{8'h00, 8'h01, 8'h08, ONES, 32'h0, 16'h9000},
      '{8'h00, 8'h01, 8'h00, 32'h0, 32'h0, 16'h63C3},
      '{8'h01, 8'h01, 8'h10, ONES, NEWC, 16'h9000},
      '{8'h00, 8'h01, 8'h08, ONES, 32'h0, 16'h63C2},
      '{8'h00, 8'h01, 8'h08, NEWC, 32'h0, 16'h9000},
      '{8'h01, 8'h01, 8'h10, 32'h0, 32'h0, 16'h63C2},
      '{8'h01, 8'h01, 8'h10, 32'h0, 32'h0, 16'h63C1},
      '{8'h01, 8'h01, 8'h10, 32'h0, 32'h0, 16'h63C0},
      '{8'h00, 8'h01, 8'h08, NEWC, 32'h0, 16'h6983},
      '{8'h00, 8'h01, 8'h00, 32'h0, 32'h0, 16'h6983},
      '{8'h01, 8'h01, 8'h10, NEWC, ONES, 16'h6983},
      '{8'h00, 8'h00, 8'h00, 32'h0, 32'h0, 16'h6A86},
      '{8'h00, 8'h41, 8'h00, 32'h0, 32'h0, 16'h6A86},
      '{8'h00, 8'h81, 8'h00, 32'h0, 32'h0, 16'h63C3},
      '{8'h03, 8'h02, 8'h08, ONES, 32'h0, 16'h9000}, // disable slot 2
      '{8'h00, 8'h02, 8'h08, ONES, 32'h0, 16'h6985},
      '{8'h00, 8'h02, 8'h00, 32'h0, 32'h0, 16'h63C3}
   };

   secv_code_ctrl #(.NUM_SLOTS(64)) secv_code_ctrl_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
   );

   secv_term secv_term_i (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );

   // 50 mhz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic run(input secv_row_t r);
      secv_term_i.cmd(r.op, r.p2, r.lc, r.a, r.b, q);
      check({16'h0, q[15:0]}, {16'h0, r.sw}, "status word");
   endtask

   task automatic grant(input logic [5:0] s, input logic g);
      secv_term_i.xfer(1'b1, OFS_ACCESS, {26'h0, s}, q, e);
      secv_term_i.xfer(1'b0, OFS_ACCESS, 32'h0, q, e);
      check({31'h0, q[8]}, {31'h0, g}, "grant");
   endtask

   task automatic summarize();
      if (failures == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // watchdog: the sequence needs well under 3000 cycles
   initial begin
      #200000;
      failures++;
      summarize();
   end

   // main sequence
   initial begin
      failures     = 0;
      total_checks = 0;
      presetn      = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      secv_term_i.xfer(1'b0, OFS_RESULT, 32'h0, q, e);
      check(q, 32'h00069000, "result after reset");   // reset slot state: retries 3 in bits 18:17
      secv_term_i.xfer(1'b0, 8'h40, 32'h0, q, e);
      check({31'h0, e}, 32'h1, "unmapped error");
      foreach (rows[i]) run(rows[i]);
      // failures on slot 3 counted across a session boundary
      run('{8'h00, 8'h03, 8'h08, 32'h0, 32'h0, 16'h63C2});
      secv_term_i.xfer(1'b1, OFS_SESSION, 32'h1, q, e);
      run('{8'h00, 8'h03, 8'h08, 32'h0, 32'h0, 16'h63C1});
      run('{8'h00, 8'h03, 8'h08, 32'h0, 32'h0, 16'h63C0});
      grant(6'h01, 1'b0);
      grant(6'h02, 1'b1);
      run('{8'h00, 8'h04, 8'h08, ONES, 32'h0, 16'h9000});
      grant(6'h04, 1'b1);
      secv_term_i.xfer(1'b1, OFS_SESSION, 32'h1, q, e);
      grant(6'h04, 1'b0);
      // unblock stand-in, enable, wrong length and unknown instruction
      run('{8'h02, 8'h01, 8'h08, NEWC, 32'h0, 16'h9000});
      grant(6'h01, 1'b0);
      run('{8'h00, 8'h01, 8'h08, NEWC, 32'h0, 16'h9000});
      grant(6'h01, 1'b1);
      run('{8'h00, 8'h01, 8'h04, NEWC, 32'h0, 16'h6700});
      run('{8'h07, 8'h01, 8'h08, NEWC, 32'h0, 16'h6D00});
      run('{8'h04, 8'h02, 8'h08, ONES, 32'h0, 16'h9000});
      run('{8'h00, 8'h02, 8'h08, ONES, 32'h0, 16'h9000});
      // interrupt: masked, unmasked, cleared by read
      check({31'h0, irq}, 32'h0, "irq masked");
      secv_term_i.xfer(1'b1, OFS_IRQ_MASK, 32'h7, q, e);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h1, "irq raised");
      secv_term_i.xfer(1'b0, OFS_IRQ_STATUS, 32'h0, q, e);
      check(q, 32'h7, "irq status");
      secv_term_i.xfer(1'b0, OFS_IRQ_STATUS, 32'h0, q, e);
      check(q, 32'h0, "irq status cleared");
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0, "irq dropped");
      // mid-run reset: slot 3 comes back unblocked with three attempts
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({31'h0, irq}, 32'h0, "irq after reset");
      run('{8'h00, 8'h03, 8'h00, 32'h0, 32'h0, 16'h63C3});
      summarize();
   end
endmodule // test_secv_code_ctrl
